// file: include/perf_event_select_map.vh
// register offsets, field positions, reset values and event codes of the event selector
`ifndef PERF_EVENT_SELECT_MAP_VH
`define PERF_EVENT_SELECT_MAP_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define SEL_OFS          8'h00
`define CNT_OFS          8'h04
`define CNT_STRIDE_LOG2  3
`define STATUS_OFS       8'h40

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SEL_EVT_LSB      0
`define SEL_UM_LSB       8
`define SEL_EN_BIT       22
`define SEL_RST          32'h00000000
`define SEL_EVT_RST      8'h00
`define SEL_UM_RST       8'h00
`define CNT_RST          32'h00000000
`define STS_STREAM_BIT   8
`define PFQ_DEPTH        3'h4

// ----------------------------------------
// event codes
// ----------------------------------------
`define EV_L1_WB         8'h28
`define EV_LAST_LEVEL    8'h2E
`define EV_UNHALTED      8'h3C
`define EV_DATA_XLATE    8'h49
`define EV_LOAD_HIT_PRE  8'h4C
`define EV_PREFETCH      8'h4E
`define EV_NESTED_WALK   8'h4F
`define EV_L1_LINES      8'h51
`define EV_LOAD_LOCK     8'h52
`define EV_OUTSTANDING   8'h60
`define EV_LOCK_CYCLES   8'h63
`define EV_IO            8'h6C
`define EV_FETCH         8'h80
`define EV_INSTR_XLATE   8'h85
`define EV_LEN_STALL     8'h87
`define EV_BR_EXEC       8'h88
`define EV_BR_MISP       8'h89
`define EV_RES_STALL     8'hA2

// ----------------------------------------
// unit masks
// ----------------------------------------
`define UM_NONE          8'h00
`define UM_BIT0          8'h01
`define UM_BIT1          8'h02
`define UM_BIT2          8'h04
`define UM_BIT3          8'h08
`define UM_BIT4          8'h10
`define UM_BIT5          8'h20
`define UM_BIT7          8'h80
`define UM_LOW_NIBBLE    8'h0F
`define UM_FETCH_ALL     8'h03
`define UM_LLC_MISS      8'h41
`define UM_LLC_ACCESS    8'h4F
`define BR_MISP_ZERO     7'h12

`endif

// file: src/perf_event_select.v
// event-select decoder with programmable counters behind an apb slave
`timescale 1ns/10ps
`include "perf_event_select_map.vh"

module perf_event_select #(
    parameter NUM_CNT = 4,
    parameter OUT_W   = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg              pready,
    output reg  [31:0]      prdata,
    output reg              pslverr,
    // cache and lock sources
    input  wire             l1_writeback_all_states,
    input  wire             last_level_miss,
    input  wire             last_level_access,
    input  wire             l1_fill,
    input  wire             l1_modified_fill,
    input  wire             l1_modified_evict,
    input  wire             modified_snoop_eviction,
    input  wire             load_lock_fill_accept,
    input  wire             load_hit_prefetch,
    input  wire             dual_cache_lock_cycles,
    input  wire             data_line_lock_cycles,
    input  wire             io_done,
    // thread state
    input  wire             thread_halted,
    input  wire             timestamp_tick,
    // data translation
    input  wire             data_xlate_walk_miss,
    input  wire             data_xlate_walk_done,
    input  wire             data_xlate_walk_busy,
    input  wire             data_xlate_second_hit,
    input  wire             data_xlate_dir_entry_miss,
    input  wire             data_xlate_large_done,
    input  wire             nested_walk_busy,
    // instruction translation
    input  wire             instr_xlate_walk_miss,
    input  wire             instr_xlate_walk_done,
    input  wire             instr_xlate_walk_busy,
    input  wire             instr_xlate_second_level_hit,
    input  wire             instr_xlate_large_done,
    // prefetchers
    input  wire             stream_train,
    input  wire             stream_req,
    input  wire             ip_req,
    input  wire             l1_data_hit,
    input  wire             prefetch_dispatch,
    input  wire             prefetch_miss,
    // outstanding off-core reads, occupancy per cycle
    input  wire [OUT_W-1:0] out_demand_data,
    input  wire [OUT_W-1:0] out_demand_code,
    input  wire [OUT_W-1:0] out_demand_own,
    input  wire [OUT_W-1:0] out_prefetch_read,
    // instruction fetch
    input  wire             fetch_hit,
    input  wire             fetch_miss_busy,
    input  wire             fetch_stall,
    // length decoder
    input  wire             length_prefix_stall,
    input  wire             length_mru_stall,
    input  wire             length_queue_full,
    input  wire             length_regen_stall,
    // branches, class bits: cond, direct, ind, ret, dcall, icall, taken
    input  wire             branch_exec,
    input  wire [6:0]       branch_class,
    input  wire             branch_mispredict,
    // allocator
    input  wire             alloc_stall,
    input  wire             load_buffer_stall
);

    localparam INC_W = OUT_W + 2;

    // ----------------------------------------
    // prefetch queue and streamer
    // ----------------------------------------
    reg        stream_active_q;
    reg  [2:0] pfq_cnt_q;
    reg  [2:0] pfq_cnt_d;
    reg  [1:0] push_cnt;
    reg        miss_busy_q;
    wire       stream_push;
    wire       fetch_miss_once;

    assign stream_push = stream_req & stream_active_q;

    always @* begin
        // both prefetchers may push in one cycle
        push_cnt  = {1'b0, stream_push} + {1'b0, ip_req};
        pfq_cnt_d = pfq_cnt_q;
        if (prefetch_dispatch && pfq_cnt_q != 3'd0) begin
            pfq_cnt_d = pfq_cnt_q - 3'd1;
        end
        if ({1'b0, pfq_cnt_d} + {2'b00, push_cnt} > `PFQ_DEPTH) begin
            pfq_cnt_d = `PFQ_DEPTH;
        end else begin
            pfq_cnt_d = pfq_cnt_d + {1'b0, push_cnt};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            stream_active_q <= 1'b0;
            pfq_cnt_q       <= 3'd0;
            miss_busy_q     <= 1'b0;
        end else begin
            // a hit stops the streamer, even against a new train
            if (l1_data_hit) begin
                stream_active_q <= 1'b0;
            end else if (stream_train) begin
                stream_active_q <= 1'b1;
            end
            pfq_cnt_q   <= pfq_cnt_d;
            miss_busy_q <= fetch_miss_busy;
        end
    end

    // edge detector idles low, as its input does after reset
    // a miss counts once, on its first outstanding cycle
    assign fetch_miss_once = fetch_miss_busy & ~miss_busy_q;

    // ----------------------------------------
    // branch classes
    // ----------------------------------------
    wire [6:0] misp_class;

    assign misp_class = branch_class & ~`BR_MISP_ZERO;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire [2:0] reg_idx;
    wire       is_status;
    wire       in_range;
    wire       setup;
    wire       wr_take;

    assign reg_idx   = paddr[`CNT_STRIDE_LOG2+2:`CNT_STRIDE_LOG2];
    assign is_status = (paddr == `STATUS_OFS);
    // indices past 7 would reach the status page
    assign in_range  = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00)
                       && ({1'b0, reg_idx} < NUM_CNT);
    assign setup     = psel & ~penable;
    // writes land only at the edge where the master sees pready
    assign wr_take   = psel & penable & pready & pwrite & ~pslverr;

    // ----------------------------------------
    // counters
    // ----------------------------------------
    wire [32*NUM_CNT-1:0] sel_flat;
    wire [32*NUM_CNT-1:0] cnt_flat;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi = gi + 1) begin : g_cnt
            reg  [7:0]       evt_q;
            reg  [7:0]       um_q;
            reg              en_q;
            reg  [31:0]      cnt_q;
            reg  [INC_W-1:0] inc;
            reg              allowed;
            wire             hit_sel;
            wire             hit_cnt;

            assign hit_sel = wr_take && reg_idx == gi && paddr[2:0] == `SEL_OFS;
            assign hit_cnt = wr_take && reg_idx == gi && paddr[2:0] == `CNT_OFS;
            assign sel_flat[32*gi+31:32*gi] = {9'h000, en_q, 6'h00, um_q, evt_q};
            assign cnt_flat[32*gi+31:32*gi] = cnt_q;

            always @* begin
                inc     = {INC_W{1'b0}};
                allowed = 1'b1;
                // restricted events only on their counters
                case (evt_q)
                    `EV_LOAD_HIT_PRE: allowed = (gi < 2);
                    `EV_PREFETCH:     allowed = (gi < 2);
                    `EV_L1_LINES:     allowed = (gi < 2);
                    `EV_LOCK_CYCLES:  allowed = (gi < 2);
                    `EV_OUTSTANDING:  allowed = (gi == 0);
                    default:          allowed = 1'b1;
                endcase

                case ({evt_q, um_q})
                    {`EV_L1_WB, `UM_LOW_NIBBLE}:      inc[0] = l1_writeback_all_states;
                    {`EV_LAST_LEVEL, `UM_LLC_MISS}:   inc[0] = last_level_miss;
                    {`EV_LAST_LEVEL, `UM_LLC_ACCESS}: inc[0] = last_level_access;
                    {`EV_UNHALTED, `UM_NONE}:         inc[0] = ~thread_halted;
                    {`EV_UNHALTED, `UM_BIT0}:         inc[0] = timestamp_tick & ~thread_halted;
                    {`EV_DATA_XLATE, `UM_BIT0}:       inc[0] = data_xlate_walk_miss;
                    {`EV_DATA_XLATE, `UM_BIT1}:       inc[0] = data_xlate_walk_done;
                    {`EV_DATA_XLATE, `UM_BIT2}:       inc[0] = data_xlate_walk_busy;
                    {`EV_DATA_XLATE, `UM_BIT4}:       inc[0] = data_xlate_second_hit;
                    {`EV_DATA_XLATE, `UM_BIT5}:       inc[0] = data_xlate_dir_entry_miss;
                    {`EV_DATA_XLATE, `UM_BIT7}:       inc[0] = data_xlate_large_done;
                    {`EV_LOAD_HIT_PRE, `UM_BIT0}:     inc[0] = load_hit_prefetch;
                    {`EV_PREFETCH, `UM_BIT0}:         inc[0] = prefetch_dispatch
                                                               && pfq_cnt_q != 3'd0;
                    {`EV_PREFETCH, `UM_BIT1}:         inc[0] = prefetch_miss;
                    {`EV_PREFETCH, `UM_BIT2}:         inc[1:0] = push_cnt;
                    {`EV_NESTED_WALK, `UM_BIT4}:      inc[0] = nested_walk_busy;
                    {`EV_L1_LINES, `UM_BIT0}:         inc[0] = l1_fill;
                    {`EV_L1_LINES, `UM_BIT1}:         inc[0] = l1_modified_fill;
                    {`EV_L1_LINES, `UM_BIT2}:         inc[0] = l1_modified_evict;
                    {`EV_L1_LINES, `UM_BIT3}:         inc[0] = modified_snoop_eviction;
                    {`EV_LOAD_LOCK, `UM_BIT0}:        inc[0] = load_lock_fill_accept;
                    {`EV_OUTSTANDING, `UM_BIT0}:      inc = {2'b00, out_demand_data};
                    {`EV_OUTSTANDING, `UM_BIT1}:      inc = {2'b00, out_demand_code};
                    {`EV_OUTSTANDING, `UM_BIT2}:      inc = {2'b00, out_demand_own};
                    {`EV_OUTSTANDING, `UM_BIT3}:      inc = {2'b00, out_demand_data}
                                                            + {2'b00, out_demand_code}
                                                            + {2'b00, out_prefetch_read};
                    {`EV_LOCK_CYCLES, `UM_BIT0}:      inc[0] = dual_cache_lock_cycles;
                    {`EV_LOCK_CYCLES, `UM_BIT1}:      inc[0] = data_line_lock_cycles;
                    {`EV_IO, `UM_BIT0}:               inc[0] = io_done;
                    {`EV_FETCH, `UM_BIT0}:            inc[0] = fetch_hit;
                    {`EV_FETCH, `UM_BIT1}:            inc[0] = fetch_miss_once;
                    {`EV_FETCH, `UM_FETCH_ALL}:       inc[1:0] = {1'b0, fetch_hit}
                                                                 + {1'b0, fetch_miss_once};
                    {`EV_FETCH, `UM_BIT2}:            inc[0] = fetch_stall;
                    {`EV_INSTR_XLATE, `UM_BIT0}:      inc[0] = instr_xlate_walk_miss;
                    {`EV_INSTR_XLATE, `UM_BIT1}:      inc[0] = instr_xlate_walk_done;
                    {`EV_INSTR_XLATE, `UM_BIT2}:      inc[0] = instr_xlate_walk_busy;
                    {`EV_INSTR_XLATE, `UM_BIT4}:      inc[0] = instr_xlate_second_level_hit;
                    {`EV_INSTR_XLATE, `UM_BIT7}:      inc[0] = instr_xlate_large_done;
                    {`EV_LEN_STALL, `UM_BIT0}:        inc[0] = length_prefix_stall;
                    {`EV_LEN_STALL, `UM_BIT1}:        inc[0] = length_mru_stall;
                    {`EV_LEN_STALL, `UM_BIT2}:        inc[0] = length_queue_full;
                    {`EV_LEN_STALL, `UM_BIT3}:        inc[0] = length_regen_stall;
                    {`EV_LEN_STALL, `UM_LOW_NIBBLE}:  inc[0] = length_prefix_stall
                                                               | length_mru_stall
                                                               | length_queue_full
                                                               | length_regen_stall;
                    {`EV_RES_STALL, `UM_BIT0}:        inc[0] = alloc_stall;
                    {`EV_RES_STALL, `UM_BIT1}:        inc[0] = load_buffer_stall;
                    default: begin
                        if (evt_q == `EV_BR_EXEC) begin
                            inc[0] = branch_exec && (um_q[6:0] & branch_class) != 7'h00;
                        end else if (evt_q == `EV_BR_MISP) begin
                            inc[0] = branch_exec && branch_mispredict
                                     && (um_q[6:0] & misp_class) != 7'h00;
                        end
                    end
                endcase
            end

            always @(posedge clk) begin
                if (reset) begin
                    evt_q <= `SEL_EVT_RST;
                    um_q  <= `SEL_UM_RST;
                    en_q  <= 1'b0;
                    cnt_q <= `CNT_RST;
                end else begin
                    if (hit_sel) begin
                        evt_q <= pwdata[`SEL_EVT_LSB+7:`SEL_EVT_LSB];
                        um_q  <= pwdata[`SEL_UM_LSB+7:`SEL_UM_LSB];
                        en_q  <= pwdata[`SEL_EN_BIT];
                    end
                    // software load wins over a same-cycle increment
                    if (hit_cnt) begin
                        cnt_q <= pwdata;
                    end else if (en_q && allowed) begin
                        cnt_q <= cnt_q + {{(32-INC_W){1'b0}}, inc};
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // apb answer, zero wait states
    // ----------------------------------------
    reg [31:0] rd_mux;
    reg        err_d;
    integer    k;

    always @* begin
        rd_mux = 32'h00000000;
        err_d  = 1'b0;
        if (is_status) begin
            rd_mux = {23'h000000, stream_active_q, 5'h00, pfq_cnt_q};
            err_d  = pwrite;
        end else if (in_range) begin
            for (k = 0; k < NUM_CNT; k = k + 1) begin
                if (reg_idx == k) begin
                    rd_mux = paddr[2] ? cnt_flat[32*k+:32] : sel_flat[32*k+:32];
                end
            end
        end else begin
            err_d = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            // answer is set up during the setup cycle
            pready  <= setup;
            pslverr <= setup & err_d;
            // read word frozen at setup, held until the next read
            if (setup && !pwrite) begin
                prdata <= err_d ? 32'h00000000 : rd_mux;
            end
        end
    end

endmodule

// file: bench/core_event_source.sv
// behavioural model of the core event lines feeding the selector
`timescale 1ns/10ps
module core_event_source (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // command from the bench
    input  wire [43:0] hold,
    input  wire [5:0]  line,
    input  wire [7:0]  len,
    input  wire        go,
    // event lines
    output wire [43:0] ev
);
    reg [7:0] left_q;
    reg [5:0] line_q;

    // ----------------------------------------
    // burst generator
    // ----------------------------------------
    // a burst inverts a held level, so a held halt line can drop for n cycles
    always @(posedge clk) begin
        if (reset) begin
            left_q <= 8'h00;
            line_q <= 6'h00;
        end else if (go) begin
            left_q <= len;
            line_q <= line;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign ev = hold ^ ((left_q != 8'h00) ? (44'h1 << line_q) : 44'h0);
endmodule

// file: bench/perf_event_select_asserts.sv
// port-level checks of the event selector's apb slave and status word
`timescale 1ns/10ps
`include "perf_event_select_map.vh"
module perf_event_select_asserts #(
    parameter NUM_CNT = 4
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // apb
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire        pready,
    input  wire [31:0] prdata,
    input  wire        pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire bad_addr  = paddr > `STATUS_OFS || paddr[1:0] != 2'b00 ||
                     (paddr < `STATUS_OFS && paddr[7:3] >= NUM_CNT);
    wire status_rd = paddr == `STATUS_OFS && !pwrite;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_refused_read;
        s_setup ##1 (pready && pslverr && !pwrite);
    endsequence
    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_ready_single;
        pready |=> !pready;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_refuse_bad;
        psel && !penable && bad_addr |=> pslverr;
    endproperty
    property p_status_ro;
        psel && !penable && pwrite && paddr == `STATUS_OFS |=> pslverr;
    endproperty
    property p_accept_good;
        psel && !penable && !bad_addr && !(pwrite && paddr == `STATUS_OFS) |=> !pslverr;
    endproperty
    property p_refused_zero;
        s_refused_read |-> prdata == 32'h00000000;
    endproperty
    property p_queue_depth;
        pready && status_rd |-> prdata[2:0] <= 3'h4 && prdata[7:3] == 5'h00
                                && prdata[31:9] == 23'h0;
    endproperty
    property p_prdata_holds;
        $changed(prdata) |-> $rose(pready) && !pwrite;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    a_ready_single: assert property (p_ready_single) else $error("ready longer than a cycle");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_refuse_bad: assert property (p_refuse_bad) else $error("unmapped access accepted");
    a_status_ro: assert property (p_status_ro) else $error("status write accepted");
    a_accept_good: assert property (p_accept_good) else $error("mapped access refused");
    a_refused_zero: assert property (p_refused_zero) else $error("refused read data not zero");
    a_queue_depth: assert property (p_queue_depth) else $error("status word out of range");
    a_prdata_holds: assert property (p_prdata_holds) else $error("read data moved off a read");
endmodule

// file: bench/perf_event_select_tb_top.sv
// self-checking bench: programs selectors over apb and fires core events
`timescale 1ns/10ps
`include "perf_event_select_map.vh"
module perf_event_select_tb_top;
    localparam N = 6'h3F;
    reg         clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    reg  [7:0]  paddr = 8'h00, plen = 8'h00;
    reg  [31:0] pwdata = 32'h0, r;
    reg  [43:0] hold = 44'h0;
    reg  [5:0]  pline = 6'h00;
    reg         e;
    wire        pready, pslverr;
    wire [31:0] prdata;
    wire [43:0] ev;
    integer     errors = 0, compares = 0, cycles = 0, i;
    always #2 clk = ~clk;
    core_event_source src_u (.clk(clk), .reset(reset), .hold(hold), .line(pline), .len(plen),
        .go(go), .ev(ev));
    perf_event_select #(.NUM_CNT(4), .OUT_W(4)) dut_u (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .l1_writeback_all_states(ev[0]),
        .last_level_miss(ev[1]), .last_level_access(ev[2]), .l1_fill(ev[3]),
        .l1_modified_fill(ev[4]), .l1_modified_evict(ev[5]), .modified_snoop_eviction(ev[6]),
        .load_lock_fill_accept(ev[7]), .load_hit_prefetch(ev[8]), .dual_cache_lock_cycles(ev[9]),
        .data_line_lock_cycles(ev[10]), .io_done(ev[11]), .thread_halted(ev[12]),
        .timestamp_tick(ev[13]), .data_xlate_walk_miss(ev[14]), .data_xlate_walk_done(ev[15]),
        .data_xlate_walk_busy(ev[16]), .data_xlate_second_hit(ev[17]),
        .data_xlate_dir_entry_miss(ev[18]), .data_xlate_large_done(ev[19]),
        .nested_walk_busy(ev[20]), .instr_xlate_walk_miss(ev[21]), .instr_xlate_walk_done(ev[22]),
        .instr_xlate_walk_busy(ev[23]), .instr_xlate_second_level_hit(ev[24]),
        .instr_xlate_large_done(ev[25]), .stream_train(ev[26]), .stream_req(ev[27]),
        .ip_req(ev[28]), .l1_data_hit(ev[29]), .prefetch_dispatch(ev[30]), .prefetch_miss(ev[31]),
        .out_demand_data(ev[43] ? 4'h3 : 4'h0), .out_demand_code(ev[43] ? 4'h2 : 4'h0),
        .out_demand_own(ev[43] ? 4'h5 : 4'h0), .out_prefetch_read(ev[43] ? 4'h1 : 4'h0),
        .fetch_hit(ev[32]), .fetch_miss_busy(ev[33]), .fetch_stall(ev[34]),
        .length_prefix_stall(ev[35]), .length_mru_stall(ev[36]), .length_queue_full(ev[37]),
        .length_regen_stall(ev[38]), .branch_exec(ev[39]), .branch_class(7'h13),
        .branch_mispredict(ev[40]), .alloc_stall(ev[41]), .load_buffer_stall(ev[42]));
    task results;
        begin
            $display("checks %0d mismatches %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors = errors + 1;
            results;
        end
    end
    task chk(input [31:0] g, input [31:0] x);
        begin
            compares = compares + 1;
            if (g !== x) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            do begin
                @(posedge clk);
            end while (pready !== 1'b1);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task pulse(input [5:0] pl, input [7:0] n);
        begin
            @(posedge clk);
            pline <= pl;
            plen <= n;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (n + 2) @(posedge clk);
        end
    endtask
    // one selector pass: hold a level, arm, clear, fire a burst, read back
    task t(input [7:0] ev_c, input [7:0] um, input [2:0] c, input [5:0] hl, input [5:0] pl,
           input [7:0] n, input [31:0] x);
        begin
            if (hl != N) begin
                @(posedge clk);
                hold[hl] <= 1'b1;
            end
            apb(1'b1, `SEL_OFS + {2'b00, c, 3'b000}, (32'h1 << `SEL_EN_BIT) | {16'h0, um, ev_c});
            apb(1'b1, `CNT_OFS + {2'b00, c, 3'b000}, 32'h0);
            pulse(pl, n);
            apb(1'b0, `CNT_OFS + {2'b00, c, 3'b000}, 32'h0);
            chk(r, x);
            // disarm before the held level drops, or its release would count
            apb(1'b1, `SEL_OFS + {2'b00, c, 3'b000}, 32'h0);
            @(posedge clk);
            hold <= 44'h0;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, `SEL_OFS, 32'h0);
        chk(r, `SEL_RST);
        apb(1'b0, `CNT_OFS, 32'h0);
        chk(r, `CNT_RST);
        apb(1'b1, `SEL_OFS, 32'h00400F28);
        apb(1'b0, `SEL_OFS, 32'h0);
        chk(r, 32'h00400F28);
        $display("reset and readback test done");
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b0, (i == 0) ? 8'h44 : (i == 1) ? 8'h02 : (i == 2) ? 8'h20 : 8'h3C, 32'h0);
            chk({31'h0, e}, 32'h1);
            chk(r, 32'h0);
        end
        apb(1'b1, `STATUS_OFS, 32'h0000FFFF);
        chk({31'h0, e}, 32'h1);
        $display("refusal test done");
        t(8'h28, 8'h0F, 0, N, 0, 3, 3);
        t(8'h2E, 8'h41, 1, N, 1, 5, 5);
        t(8'h2E, 8'h4F, 2, N, 2, 4, 4);
        t(8'h3C, 8'h00, 3, 12, 12, 6, 6);
        t(8'h3C, 8'h01, 0, 12, 13, 4, 0);
        t(8'h3C, 8'h01, 1, N, 13, 4, 4);
        t(8'h49, 8'h01, 2, N, 14, 2, 2);
        t(8'h49, 8'h04, 3, N, 16, 6, 6);
        t(8'h49, 8'h02, 1, N, 15, 2, 2);
        t(8'h49, 8'h20, 0, N, 18, 3, 3);
        t(8'h4C, 8'h01, 1, N, 8, 3, 3);
        t(8'h4C, 8'h01, 2, N, 8, 3, 0);
        t(8'h4E, 8'h04, 1, N, 28, 6, 6);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk(r, 32'h4);
        t(8'h4E, 8'h01, 0, N, 30, 6, 4);
        t(8'h4E, 8'h02, 0, N, 31, 3, 3);
        t(8'h4E, 8'h04, 3, N, 27, 2, 0);
        t(8'h4F, 8'h10, 3, N, 20, 7, 7);
        t(8'h51, 8'h01, 0, N, 3, 2, 2);
        t(8'h51, 8'h02, 1, N, 4, 2, 2);
        t(8'h51, 8'h04, 0, N, 5, 3, 3);
        t(8'h51, 8'h08, 1, N, 6, 4, 4);
        t(8'h51, 8'h01, 3, N, 3, 2, 0);
        t(8'h52, 8'h01, 2, N, 7, 3, 3);
        t(8'h60, 8'h01, 0, N, 43, 4, 3 * 4);
        t(8'h60, 8'h02, 0, N, 43, 4, 2 * 4);
        t(8'h60, 8'h04, 0, N, 43, 4, 5 * 4);
        t(8'h60, 8'h08, 0, N, 43, 4, (3 + 2 + 1) * 4);
        t(8'h60, 8'h08, 1, N, 43, 4, 0);
        t(8'h63, 8'h01, 0, N, 9, 5, 5);
        t(8'h63, 8'h01, 2, N, 9, 5, 0);
        t(8'h63, 8'h02, 1, N, 10, 5, 5);
        t(8'h6C, 8'h01, 3, N, 11, 3, 3);
        t(8'h80, 8'h01, 0, N, 32, 3, 3);
        t(8'h80, 8'h02, 1, N, 33, 5, 1);
        t(8'h80, 8'h03, 3, N, 32, 3, 3);
        t(8'h80, 8'h04, 2, N, 34, 4, 4);
        t(8'h87, 8'h01, 0, N, 35, 3, 3);
        t(8'h87, 8'h04, 1, N, 37, 2, 2);
        t(8'h87, 8'h08, 2, N, 38, 2, 2);
        t(8'h87, 8'h0F, 3, N, 36, 3, 3);
        t(8'h85, 8'h10, 0, N, 24, 2, 2);
        t(8'h85, 8'h04, 1, N, 23, 3, 3);
        t(8'h85, 8'h01, 2, N, 21, 2, 2);
        t(8'h88, 8'h01, 2, N, 39, 3, 3);
        t(8'h88, 8'h08, 3, N, 39, 3, 0);
        t(8'h88, 8'h7F, 0, N, 39, 4, 4);
        t(8'h89, 8'h01, 1, 40, 39, 3, 3);
        t(8'h89, 8'h01, 2, N, 39, 3, 0);
        t(8'h89, 8'h02, 3, 40, 39, 3, 0);
        t(8'h89, 8'h10, 0, 40, 39, 3, 0);
        t(8'hA2, 8'h01, 1, N, 41, 3, 3);
        t(8'hA2, 8'h02, 2, N, 42, 2, 2);
        $display("event table test done");
        pulse(26, 1);
        pulse(27, 1);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk(r, (32'h1 << `STS_STREAM_BIT) | 32'h1);
        pulse(29, 1);
        pulse(27, 2);
        pulse(28, 2);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk(r, 32'h3);
        $display("prefetcher test done");
        results;
    end
endmodule
bind perf_event_select perf_event_select_asserts #(.NUM_CNT(NUM_CNT)) chk_u (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
